/* cmw_pkg.sv */
// Package of constants for the charger mode and watchdog register block
package cmw_pkg;
  // Register map
  localparam logic [7:0] CMW_OFS_INPUT_SRC  = 8'h00;
  localparam logic [7:0] CMW_OFS_THERM_VOFS = 8'h01;
  localparam logic [7:0] CMW_RST_INPUT_SRC  = 8'h08;
  localparam logic [7:0] CMW_RST_THERM_VOFS = 8'h05;
  // Target address on the serial bus
  localparam logic [6:0] CMW_TARGET_ADDR    = 7'h6a;
  // Field positions
  localparam int CMW_HIZ_BIT     = 7;
  localparam int CMW_EXTPIN_BIT  = 6;
  localparam int CMW_COLD_BIT    = 5;
  // Input current cap scaling in mA
  localparam logic [11:0] CMW_CAP_OFS_MA  = 12'h064;
  localparam logic [11:0] CMW_CAP_STEP_MA = 12'h032;
  // Input voltage floor offset scaling and clamps in mV
  localparam logic [15:0] CMW_VOFS_STEP_MV = 16'h0064;
  localparam logic [15:0] CMW_VFLOOR_MIN_MV = 16'h0f3c;
  localparam logic [15:0] CMW_VFLOOR_MAX_MV = 16'h3bc4;
  localparam logic [15:0] CMW_NOLOAD_HI_MV  = 16'h1770;
  // Boost thermal thresholds in hundredths of a percent
  localparam logic [15:0] CMW_HOT0_CP  = 16'h0d93;
  localparam logic [15:0] CMW_HOT1_CP  = 16'h0ebf;
  localparam logic [15:0] CMW_HOT2_CP  = 16'h0c35;
  localparam logic [15:0] CMW_COLD0_CP = 16'h1e14;
  localparam logic [15:0] CMW_COLD1_CP = 16'h1f40;
  // Safety timer: 12 hours as seconds, with a 1 s tick from sys_clk
  localparam int CMW_CLK_HZ        = 100_000_000;
  localparam int CMW_SAFETY_HOURS  = 12;
  localparam int CMW_SAFETY_S      = CMW_SAFETY_HOURS * 3600;
  localparam int CMW_TICK_CYCLES   = CMW_CLK_HZ;
  // Watchdog period encodings, in seconds
  localparam logic [1:0] CMW_WD_OFF = 2'b00;
  localparam int CMW_WD_S1 = 40;
  localparam int CMW_WD_S2 = 80;
  localparam int CMW_WD_S3 = 160;
  // Operating modes
  typedef enum logic [0:0] {
    CMW_DEFAULT = 1'b0,
    CMW_HOST    = 1'b1
  } cmw_mode_t;
endpackage : cmw_pkg

/* cmw_regs.sv */
// Charger mode, watchdog and input-limit register block
// Behaviour
// RL1 - The expired flag is high in default mode and low in host mode.
// RL2 - After power-on reset the block starts in default mode with all registers at defaults.
// RL3 - In default mode a 12-hour safety timer ends charging while the converter keeps running.
// RL4 - Any register write from the host moves the block into host mode.
// RL5 - The host stays in host mode by writing the restart bit in time or by setting the period to 00.
// RL6 - Expiry returns to default mode and resets registers except cap, floor, offset and switch bits; the code restores the HIZ and EXTPIN bits 7:6.
// RL7 - The block answers only to target address 0x6A with a direction bit.
// RL8 - The cap field means 100 mA plus 50 mA per step.
// RL9 - The effective cap is the lower of the register value and the external pin limit.
// RL10 - The cap field is overwritten when source detection finishes.
// RL11 - The floor offset weighs 100 mV per step, default 500 mV.
// RL12 - The floor threshold is clamped between 3.9 V and 15.3 V.
// RL13 - Above 6 V no-load input the offset is doubled.
// RL14 - The hot select decodes to 34.75, 37.75, 31.25 percent or disabled.
// RL15 - The cold select gives 77 percent at zero and 80 percent at one.
// RL16 - The restart bit clears itself after the watchdog is restarted.
// RL17 - The watchdog is a counter restarted by writes, held off at period 00, setting the flag on expiry.
`timescale 1ns/1ps
module cmw_regs
  import cmw_pkg::*;
#(
  parameter int TICK_CYCLES = CMW_TICK_CYCLES,
  parameter int SAFETY_S    = CMW_SAFETY_S
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Register access from the serial target engine
  input  wire logic        bus_valid,
  input  wire logic [6:0]  bus_dev_addr,
  input  wire logic        bus_read,
  input  wire logic [7:0]  bus_reg_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic             bus_ack,
  output logic [7:0]       bus_rdata,
  // Watchdog controls held in later registers
  input  wire logic        timer_restart_bit,
  input  wire logic [1:0]  wd_period_sel,
  // Source detection result
  input  wire logic        detect_done,
  input  wire logic [5:0]  detect_cap_code,
  // Analog inputs, digitised, and the charge request
  input  wire logic [11:0] external_current_cap_pin,
  input  wire logic [15:0] input_supply_rail_noload_mv,
  input  wire logic [15:0] input_voltage_floor_base_mv,
  input  wire logic        charge_request,
  // Status and decoded controls
  output logic             wd_expired,
  output logic             restart_clear,
  output logic             charge_enable,
  output logic             safety_timeout,
  output logic             input_highz_enable,
  output logic [11:0]      eff_cap_ma,
  output logic [15:0]      input_voltage_floor_mv,
  output logic [15:0]      boost_hot_cp,
  output logic             boost_hot_disable,
  output logic [15:0]      boost_cold_cp
);

  cmw_mode_t   mode_r;
  logic [7:0]  src_r;
  logic [7:0]  therm_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] wd_cnt_r;
  logic [31:0] safety_cnt_r;
  logic        safety_done_r;
  logic [7:0]  rdata_r;

  // Period select to seconds
  function automatic logic [31:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'b01:   wd_limit = 32'(CMW_WD_S1);
      2'b10:   wd_limit = 32'(CMW_WD_S2);
      2'b11:   wd_limit = 32'(CMW_WD_S3);
      default: wd_limit = 32'h0;
    endcase
  endfunction : wd_limit

  // Decode of the access
  wire addr_hit  = bus_valid && (bus_dev_addr == CMW_TARGET_ADDR); // RL7
  wire reg_ok    = (bus_reg_addr == CMW_OFS_INPUT_SRC) || (bus_reg_addr == CMW_OFS_THERM_VOFS);
  wire wr_src    = addr_hit && !bus_read && (bus_reg_addr == CMW_OFS_INPUT_SRC);
  wire wr_therm  = addr_hit && !bus_read && (bus_reg_addr == CMW_OFS_THERM_VOFS);
  wire any_write = addr_hit && !bus_read && reg_ok;
  wire tick      = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  wire wd_on     = (wd_period_sel != CMW_WD_OFF); // RL17
  wire restart   = any_write || timer_restart_bit; // RL5
  wire expire    = (mode_r == CMW_HOST) && wd_on && tick && !restart
                   && (wd_cnt_r + 32'h1 >= wd_limit(wd_period_sel)); // RL17

  // Unknown register offsets are refused
  assign bus_ack       = addr_hit && reg_ok;
  assign bus_rdata     = rdata_r;
  assign wd_expired    = (mode_r == CMW_DEFAULT); // RL1
  assign restart_clear = timer_restart_bit; // RL16
  assign input_highz_enable = src_r[CMW_HIZ_BIT];

  // Effective cap: register value against the pin when enabled
  wire [11:0] reg_cap_ma = CMW_CAP_OFS_MA + 12'(src_r[5:0]) * CMW_CAP_STEP_MA; // RL8
  wire        pin_lower  = src_r[CMW_EXTPIN_BIT] && (external_current_cap_pin < reg_cap_ma);
  assign eff_cap_ma = pin_lower ? external_current_cap_pin : reg_cap_ma; // RL9

  // Floor threshold with offset scaling and clamps
  wire [15:0] ofs_mv   = 16'(therm_r[4:0]) * CMW_VOFS_STEP_MV; // RL11
  wire [15:0] ofs_used = (input_supply_rail_noload_mv > CMW_NOLOAD_HI_MV) ? 16'(ofs_mv << 1) : ofs_mv; // RL13
  wire [15:0] raw_fl   = input_voltage_floor_base_mv + ofs_used;
  assign input_voltage_floor_mv = (raw_fl < CMW_VFLOOR_MIN_MV) ? CMW_VFLOOR_MIN_MV :
                                  (raw_fl > CMW_VFLOOR_MAX_MV) ? CMW_VFLOOR_MAX_MV : raw_fl; // RL12

  // Boost thermal thresholds
  assign boost_hot_cp = (therm_r[7:6] == 2'b01) ? CMW_HOT1_CP :
                        (therm_r[7:6] == 2'b10) ? CMW_HOT2_CP : CMW_HOT0_CP; // RL14
  assign boost_hot_disable = (therm_r[7:6] == 2'b11); // RL14
  assign boost_cold_cp = therm_r[CMW_COLD_BIT] ? CMW_COLD1_CP : CMW_COLD0_CP; // RL15

  // Charging stops at the safety timeout in default mode only
  assign safety_timeout = safety_done_r;
  assign charge_enable  = charge_request && !safety_done_r; // RL3

  // One-second tick divider
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  // Mode and watchdog counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r   <= CMW_DEFAULT; // RL2
      wd_cnt_r <= 32'h0;
    end else begin
      if (any_write) begin
        mode_r <= CMW_HOST; // RL4
      end else if (expire) begin
        mode_r <= CMW_DEFAULT; // RL6
      end
      if (restart || !wd_on || mode_r == CMW_DEFAULT) begin
        wd_cnt_r <= 32'h0; // RL17
      end else if (tick) begin
        wd_cnt_r <= wd_cnt_r + 32'h1;
      end
    end
  end

  // Safety timer runs while charging in default mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      safety_cnt_r  <= 32'h0;
      safety_done_r <= 1'b0;
    end else if (mode_r != CMW_DEFAULT || !charge_request) begin
      safety_cnt_r  <= 32'h0;
      safety_done_r <= 1'b0;
    end else if (tick && !safety_done_r) begin
      safety_cnt_r  <= safety_cnt_r + 32'h1;
      safety_done_r <= (safety_cnt_r + 32'h1 >= 32'(SAFETY_S)); // RL3
    end
  end

  // Register storage; expiry keeps cap and offset, restores the rest
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_r   <= CMW_RST_INPUT_SRC; // RL2
      therm_r <= CMW_RST_THERM_VOFS;
    end else begin
      // Detection owns the cap bits only, so expiry must still restore 7:6 in the same cycle
      if (wr_src) begin
        src_r <= bus_wdata;
      end else begin
        if (detect_done) begin
          src_r[5:0] <= detect_cap_code; // RL10
        end
        if (expire) begin
          src_r[7:6] <= CMW_RST_INPUT_SRC[7:6]; // RL6
        end
      end
      if (wr_therm) begin
        therm_r <= bus_wdata;
      end else if (expire) begin
        therm_r[7:5] <= CMW_RST_THERM_VOFS[7:5]; // RL6
      end
    end
  end

  // Read data captured at the access
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (addr_hit && bus_read) begin
      rdata_r <= (bus_reg_addr == CMW_OFS_INPUT_SRC) ? src_r :
                 (bus_reg_addr == CMW_OFS_THERM_VOFS) ? therm_r : 8'hff;
    end
  end

  // Checks
  property p_flag_mode;
    @(posedge sys_clk) disable iff (!arst_n) $changed(wd_expired) |-> $past(any_write) || $past(expire);
  endproperty
  a_flag_mode: assert property (p_flag_mode) else $error("flag disagrees with mode"); // RL1

  property p_write_host;
    @(posedge sys_clk) disable iff (!arst_n) any_write |=> !wd_expired;
  endproperty
  a_write_host: assert property (p_write_host) else $error("write did not enter host mode"); // RL4

  property p_expire_default;
    @(posedge sys_clk) disable iff (!arst_n) expire |=> wd_expired && therm_r[7:5] == 3'b000;
  endproperty
  a_expire_default: assert property (p_expire_default) else $error("expiry did not restore"); // RL6

  property p_keep_cap;
    @(posedge sys_clk) disable iff (!arst_n) expire && !wr_src && !detect_done |=> $stable(src_r[5:0]);
  endproperty
  a_keep_cap: assert property (p_keep_cap) else $error("cap lost on expiry"); // RL6

  property p_cap_min;
    @(posedge sys_clk) disable iff (!arst_n) eff_cap_ma <= reg_cap_ma;
  endproperty
  a_cap_min: assert property (p_cap_min) else $error("cap above register value"); // RL9

  property p_floor_clamp;
    @(posedge sys_clk) disable iff (!arst_n)
      input_voltage_floor_mv >= CMW_VFLOOR_MIN_MV && input_voltage_floor_mv <= CMW_VFLOOR_MAX_MV;
  endproperty
  a_floor_clamp: assert property (p_floor_clamp) else $error("floor out of range"); // RL12

  property p_detect;
    @(posedge sys_clk) disable iff (!arst_n) detect_done && !wr_src |=> src_r[5:0] == $past(detect_cap_code);
  endproperty
  a_detect: assert property (p_detect) else $error("cap not updated by detection"); // RL10

  property p_wd_off;
    @(posedge sys_clk) disable iff (!arst_n) !wd_on && !wd_expired |=> !wd_expired;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("expiry while disabled"); // RL17

  property p_cold;
    @(posedge sys_clk) disable iff (!arst_n) therm_r[CMW_COLD_BIT] |-> boost_cold_cp == CMW_COLD1_CP;
  endproperty
  a_cold: assert property (p_cold) else $error("cold threshold wrong"); // RL15

endmodule : cmw_regs

/* cmw_host_model.sv */
// Host-side model issuing single-byte register accesses
`timescale 1ns/1ps
module cmw_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Access request
  output logic            bus_valid,
  output logic [6:0]      bus_dev_addr,
  output logic            bus_read,
  output logic [7:0]      bus_reg_addr,
  output logic [7:0]      bus_wdata,
  // Answer
  input  wire logic       bus_ack,
  input  wire logic [7:0] bus_rdata
);
  // Idle lines carry inverted values so stale data cannot pass for fresh
  initial begin
    bus_valid = 1'b0;
    bus_dev_addr = 7'h15;
    bus_read = 1'b1;
    bus_reg_addr = 8'hf0;
    bus_wdata = 8'h5a;
  end
  // One pulse; ack taken at the sampling edge, read data at the falling edge half a cycle later
  task automatic access(input logic [6:0] dev, input logic rd, input logic [7:0] ofs,
                        input logic [7:0] wd, output logic ack, output logic [7:0] rdat);
    @(negedge sys_clk);
    bus_valid = 1'b1;
    bus_dev_addr = dev;
    bus_read = rd;
    bus_reg_addr = ofs;
    bus_wdata = wd;
    @(posedge sys_clk);
    ack = bus_ack;
    @(negedge sys_clk);
    rdat = bus_rdata;
    bus_valid = 1'b0;
    bus_dev_addr = ~dev;
    bus_read = ~rd;
    bus_reg_addr = ~ofs;
    bus_wdata = ~wd;
  endtask : access
endmodule : cmw_host_model

/* cmw_regs_bench.sv */
// Self-checking bench for the charger mode and watchdog register block
`timescale 1ns/1ps
module cmw_regs_bench;
  import cmw_pkg::*;
  // Shortened second tick and safety time keep the run small
  localparam int TICK = 10;
  localparam int SAFE = 5;
  logic        sys_clk, arst_n, bus_valid, bus_read, bus_ack, ack, rst_bit, det_done, chg_req;
  logic        wd_expired, restart_clear, charge_enable, safety_timeout, highz, hot_dis;
  logic [6:0]  bus_dev_addr;
  logic [7:0]  bus_reg_addr, bus_wdata, bus_rdata, rdat;
  logic [1:0]  wd_sel;
  logic [5:0]  det_code;
  logic [11:0] pin_ma, cap_ma;
  logic [15:0] noload_mv, base_mv, floor_mv, hot_cp, cold_cp;
  int          n_errors, num_checks, cycles;
  // No-load, base and expected floor: plain, doubled, both clamps, 6 V edge
  logic [15:0] nl_t [5] = '{16'h1388, 16'h1b58, 16'h1388, 16'h3a98, 16'h1770};
  logic [15:0] bs_t [5] = '{16'h0fa0, 16'h0fa0, 16'h0bb8, 16'h3a98, 16'h0fa0};
  logic [15:0] fl_t [5] = '{16'h1194, 16'h1388, 16'h0f3c, 16'h3bc4, 16'h1194};
  logic [15:0] hot_t [3] = '{16'h0d93, 16'h0ebf, 16'h0c35};

  cmw_host_model i_host (.sys_clk(sys_clk), .bus_valid(bus_valid), .bus_dev_addr(bus_dev_addr),
    .bus_read(bus_read), .bus_reg_addr(bus_reg_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));
  cmw_regs #(.TICK_CYCLES(TICK), .SAFETY_S(SAFE)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus_valid(bus_valid), .bus_dev_addr(bus_dev_addr), .bus_read(bus_read),
    .bus_reg_addr(bus_reg_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .timer_restart_bit(rst_bit), .wd_period_sel(wd_sel), .detect_done(det_done),
    .detect_cap_code(det_code), .external_current_cap_pin(pin_ma),
    .input_supply_rail_noload_mv(noload_mv), .input_voltage_floor_base_mv(base_mv),
    .charge_request(chg_req), .wd_expired(wd_expired), .restart_clear(restart_clear),
    .charge_enable(charge_enable), .safety_timeout(safety_timeout), .input_highz_enable(highz),
    .eff_cap_ma(cap_ma), .input_voltage_floor_mv(floor_mv), .boost_hot_cp(hot_cp),
    .boost_hot_disable(hot_dis), .boost_cold_cp(cold_cp));

  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_host.access(CMW_TARGET_ADDR, 1'b0, ofs, d, ack, rdat);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    i_host.access(CMW_TARGET_ADDR, 1'b1, ofs, 8'h00, ack, rdat);
    check_val({7'h00, ack, rdat}, {8'h01, exp});
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cyc
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard: the sequence needs about 1900 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {arst_n, rst_bit, det_done} = 3'b000;
    {wd_sel, det_code, pin_ma, chg_req} = {2'b01, 6'h04, 12'hfff, 1'b1};
    {noload_mv, base_mv, n_errors, num_checks, cycles} = '0;
    wait_cyc(8);
    arst_n = 1'b1;
    check_val(16'(wd_expired), 16'h0001);
    check_val(16'(charge_enable), 16'h0001);
    check_val(16'(cap_ma), 16'h01f4);
    check_val(cold_cp, 16'h1e14);
    for (int i = 0; i < 5; i++) begin
      noload_mv = nl_t[i];
      base_mv = bs_t[i];
      #1 check_val(floor_mv, fl_t[i]);
    end
    wait_cyc(SAFE * TICK + 20);
    check_val({15'h0, safety_timeout}, 16'h0001);
    check_val(16'(charge_enable), 16'h0000);
    rd(CMW_OFS_INPUT_SRC, 8'h08);
    rd(CMW_OFS_THERM_VOFS, 8'h05);
    check_val(16'(wd_expired), 16'h0001);
    wr(CMW_OFS_THERM_VOFS, 8'h20);
    check_val({15'h0, wd_expired}, 16'h0000);
    check_val(cold_cp, 16'h1f40);
    for (int i = 0; i < 4; i++) begin
      wr(CMW_OFS_THERM_VOFS, {i[1:0], 6'h00});
      check_val(16'(hot_dis), 16'(i == 3));
      if (i < 3) check_val(hot_cp, hot_t[i]);
    end
    wr(CMW_OFS_THERM_VOFS, 8'h1f);
    check_val(floor_mv, 16'h1bbc);
    wr(CMW_OFS_INPUT_SRC, 8'h7f);
    check_val(16'(cap_ma), 16'h0cb2);
    pin_ma = 12'h3e8;
    #1 check_val(16'(cap_ma), 16'h03e8);
    wr(CMW_OFS_INPUT_SRC, 8'h80);
    check_val(16'(highz), 16'h0001);
    det_done = 1'b1;
    wait_cyc(1);
    det_done = 1'b0;
    rd(CMW_OFS_INPUT_SRC, 8'h84);
    check_val(16'(cap_ma), 16'h012c);
    // Foreign target and unmapped offset are refused
    i_host.access(7'h6b, 1'b0, CMW_OFS_INPUT_SRC, 8'h11, ack, rdat);
    check_val(16'(ack), 16'h0000);
    i_host.access(CMW_TARGET_ADDR, 1'b1, 8'h02, 8'h00, ack, rdat);
    check_val({7'h00, ack, rdat}, 16'h00ff);
    rd(CMW_OFS_INPUT_SRC, 8'h84);
    // Watchdog of 40 ticks: restart in time, then let it expire
    wr(CMW_OFS_INPUT_SRC, 8'hff);
    wr(CMW_OFS_THERM_VOFS, 8'hff);
    wait_cyc(300);
    rst_bit = 1'b1;
    #1 check_val(16'(restart_clear), 16'h0001);
    wait_cyc(1);
    rst_bit = 1'b0;
    wait_cyc(300);
    check_val(16'(wd_expired), 16'h0000);
    wait_cyc(150);
    check_val(16'(wd_expired), 16'h0001);
    rd(CMW_OFS_INPUT_SRC, 8'h3f);
    rd(CMW_OFS_THERM_VOFS, 8'h1f);
    wd_sel = CMW_WD_OFF;
    wr(CMW_OFS_INPUT_SRC, 8'h08);
    wait_cyc(1000);
    check_val(16'(wd_expired), 16'h0000);
    close_out();
  end
endmodule : cmw_regs_bench
